/* src/rmch_top.v */
// Remote monitor and instruction handshake of a fieldbus servo slave.
`timescale 1ns/1ns
`include "rmch_regs.vh"
module rmch_top #(
  parameter MON_W = 32
) (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [`RMCH_ADDR_W-1:0] bus_addr_in,
  input wire [`RMCH_DATA_W-1:0] bus_wdata_in,
  input wire bus_wr_in,
  input wire bus_rd_in,
  output reg [`RMCH_DATA_W-1:0] bus_rdata_out,
  input wire [MON_W-1:0] mon1_data_in,
  input wire mon1_err_in,
  input wire [MON_W-1:0] mon2_data_in,
  input wire mon2_err_in,
  output reg [`RMCH_DATA_W-1:0] mon1_sel_out,
  output reg [`RMCH_DATA_W-1:0] mon2_sel_out,
  output reg [`RMCH_DATA_W-1:0] instr_code_out,
  output reg instr_start_out,
  input wire instr_done_in,
  input wire instr_err_in,
  output reg monitor_ack_bit_out,
  output reg instruction_ack_bit_out
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg [`RMCH_DATA_W-1:0] wreg_q [0:7];
  reg [`RMCH_DATA_W-1:0] rreg_q [0:7];
  reg monitor_request_bit_q;
  reg instruction_request_bit_q;
  reg two_station_q;
  integer i;

  wire [`RMCH_ADDR_W-1:0] bank;
  wire [2:0] idx;
  wire wr_wreg;
  wire wr_ctrl;
  wire wr_cfg;

  assign bank = bus_addr_in & `RMCH_BANK_MASK;
  assign idx = bus_addr_in[2:0];
  assign wr_wreg = bus_wr_in & (bank == `RMCH_WREG_LO);
  assign wr_ctrl = bus_wr_in & (bus_addr_in == `RMCH_CTRL_ADDR);
  assign wr_cfg = bus_wr_in & (bus_addr_in == `RMCH_CFG_ADDR);

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  wire mon_launch;
  wire mon_finish;
  wire mon_ack;
  wire ins_launch;
  wire ins_finish;
  wire ins_busy;
  wire ins_ack;

  // Monitor data are present on the inputs at all times, so the load completes at once.
  rmch_hs #(
    .IMMEDIATE(1)
  ) u_mon_hs (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(monitor_request_bit_q),
    .done_in(1'b0),
    .launch_out(mon_launch),
    .finish_out(mon_finish),
    .busy_out(),
    .ack_out(mon_ack)
  );

  rmch_hs #(
    .IMMEDIATE(0)
  ) u_ins_hs (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .req_in(instruction_request_bit_q),
    .done_in(instr_done_in),
    .launch_out(ins_launch),
    .finish_out(ins_finish),
    .busy_out(ins_busy),
    .ack_out(ins_ack)
  );

  // ****************************************************************
  // Monitor load and refresh
  // ****************************************************************
  wire mon_load;
  wire [`RMCH_DATA_W-1:0] mon_resp;
  wire [`RMCH_DATA_W-1:0] m1_lo;
  wire [`RMCH_DATA_W-1:0] m1_hi;
  wire [`RMCH_DATA_W-1:0] m2_lo;
  wire [`RMCH_DATA_W-1:0] m2_hi;

  // Reloading every cycle keeps values live; the master must still wait for ack first.
  assign mon_load = mon_finish | (mon_ack & monitor_request_bit_q);
  assign mon_resp = (mon1_err_in | mon2_err_in) ? `RMCH_RESP_ERR : `RMCH_RESP_OK;
  assign m1_lo = mon1_data_in[`RMCH_DATA_W-1:0];
  assign m1_hi = mon1_data_in[2*`RMCH_DATA_W-1:`RMCH_DATA_W];
  assign m2_lo = mon2_data_in[`RMCH_DATA_W-1:0];
  assign m2_hi = mon2_data_in[2*`RMCH_DATA_W-1:`RMCH_DATA_W];

  // ****************************************************************
  // Write registers, control and configuration
  // ****************************************************************
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        wreg_q[i] <= `RMCH_WORD_RST;
      end
      monitor_request_bit_q <= 1'b0;
      instruction_request_bit_q <= 1'b0;
      two_station_q <= `RMCH_CFG_RST;
    end else begin
      if (wr_wreg) begin
        wreg_q[idx] <= bus_wdata_in;
      end
      if (wr_ctrl) begin
        monitor_request_bit_q <= bus_wdata_in[`RMCH_BIT_MON];
        instruction_request_bit_q <= bus_wdata_in[`RMCH_BIT_INSTR];
      end
      if (wr_cfg) begin
        two_station_q <= bus_wdata_in[`RMCH_BIT_TWO_ST];
      end
    end
  end

  // ****************************************************************
  // Read registers
  // ****************************************************************
  // The instruction respond code is written after the monitor respond code, so when
  // both end on one edge the instruction result is the one left in slot base+2.
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      for (i = 0; i < 8; i = i + 1) begin
        rreg_q[i] <= `RMCH_WORD_RST;
      end
    end else begin
      if (mon_load) begin
        if (two_station_q) begin
          rreg_q[`RMCH_SLOT_BASE] <= m1_lo;
          rreg_q[`RMCH_SLOT_P1] <= m1_hi;
          rreg_q[`RMCH_SLOT_P5] <= m2_lo;
          rreg_q[`RMCH_SLOT_P6] <= m2_hi;
        end else begin
          rreg_q[`RMCH_SLOT_BASE] <= m1_lo;
          rreg_q[`RMCH_SLOT_P1] <= m2_lo;
        end
        rreg_q[`RMCH_SLOT_P2] <= mon_resp;
      end
      if (ins_finish) begin
        rreg_q[`RMCH_SLOT_P2] <= instr_err_in ? `RMCH_RESP_ERR : `RMCH_RESP_OK;
      end
    end
  end

  // ****************************************************************
  // Outputs toward the servo core
  // ****************************************************************
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mon1_sel_out <= `RMCH_WORD_RST;
      mon2_sel_out <= `RMCH_WORD_RST;
      instr_code_out <= `RMCH_WORD_RST;
      instr_start_out <= 1'b0;
      monitor_ack_bit_out <= 1'b0;
      instruction_ack_bit_out <= 1'b0;
    end else begin
      mon1_sel_out <= wreg_q[`RMCH_SLOT_BASE];
      if (two_station_q) begin
        mon2_sel_out <= wreg_q[`RMCH_SLOT_P2];
      end else begin
        mon2_sel_out <= wreg_q[`RMCH_SLOT_P1];
      end
      // The code is held steady for as long as the processing runs.
      if (ins_launch) begin
        instr_code_out <= wreg_q[`RMCH_SLOT_P2];
      end
      instr_start_out <= ins_launch;
      monitor_ack_bit_out <= mon_finish | (mon_ack & monitor_request_bit_q);
      // A job whose request was withdrawn still posts its code, but raises no ack.
      instruction_ack_bit_out <= instruction_request_bit_q & (ins_finish | ins_ack);
    end
  end

  // ****************************************************************
  // Bus read port
  // ****************************************************************
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_rdata_out <= `RMCH_WORD_RST;
    end else if (bus_rd_in) begin
      if (bank == `RMCH_WREG_LO) begin
        bus_rdata_out <= wreg_q[idx];
      end else if (bank == `RMCH_RREG_LO) begin
        bus_rdata_out <= rreg_q[idx];
      end else if (bus_addr_in == `RMCH_CTRL_ADDR) begin
        bus_rdata_out <= {14'h0000, instruction_request_bit_q, monitor_request_bit_q};
      end else if (bus_addr_in == `RMCH_STAT_ADDR) begin
        bus_rdata_out <= {13'h0000, ins_busy, instruction_ack_bit_out, monitor_ack_bit_out};
      end else if (bus_addr_in == `RMCH_CFG_ADDR) begin
        bus_rdata_out <= {15'h0000, two_station_q};
      end else begin
        bus_rdata_out <= `RMCH_WORD_RST;
      end
    end else begin
      bus_rdata_out <= `RMCH_WORD_RST;
    end
  end

endmodule // rmch_top

/* pkg/rmch_regs.vh */
// Constants of the remote monitor and instruction handshake block.
// Behaviour
// - A rising monitor request loads the selected monitor data and the respond code into the read registers and raises the monitor acknowledge on the same edge.
// - While the monitor request stays high the monitor values in the read registers are reloaded on every clock.
// - With one station, read base takes monitor 1 chosen by write base, read base+1 takes monitor 2 chosen by write base+1, read base+2 takes the respond code.
// - With two stations, monitor 1 chosen by write base fills read base (low half) and base+1 (high half), monitor 2 chosen by write base+2 fills read base+5 (low) and base+6 (high).
// - The master leaves an instruction code in write base+2 and a rising instruction request starts the matching processing.
// - When that processing ends the respond code goes into read base+2 and the instruction acknowledge rises on the same edge if the request is still high.
`ifndef RMCH_REGS_VH
`define RMCH_REGS_VH

// ****************************************************************
// Register bus map
// ****************************************************************
`define RMCH_ADDR_W 5
`define RMCH_DATA_W 16
`define RMCH_WREG_LO 5'h00
`define RMCH_RREG_LO 5'h08
`define RMCH_CTRL_ADDR 5'h10
`define RMCH_STAT_ADDR 5'h11
`define RMCH_CFG_ADDR 5'h12
`define RMCH_BANK_MASK 5'h18
`define RMCH_IDX_MASK 5'h07

// ****************************************************************
// Register slots
// ****************************************************************
`define RMCH_SLOT_BASE 3'h0
`define RMCH_SLOT_P1 3'h1
`define RMCH_SLOT_P2 3'h2
`define RMCH_SLOT_P5 3'h5
`define RMCH_SLOT_P6 3'h6

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define RMCH_BIT_MON 0
`define RMCH_BIT_INSTR 1
`define RMCH_BIT_TWO_ST 0
`define RMCH_WORD_RST 16'h0000
`define RMCH_CFG_RST 1'h0
`define RMCH_RESP_OK 16'h0000
`define RMCH_RESP_ERR 16'h0001

`endif

/* src/rmch_hs.v */
// One request and acknowledge handshake of the remote handshake block.
`timescale 1ns/1ns
module rmch_hs #(
  parameter IMMEDIATE = 0
) (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire req_in,
  input wire done_in,
  output wire launch_out,
  output wire finish_out,
  output wire busy_out,
  output wire ack_out
);
  reg busy_q;
  reg ack_q;
  reg req_q;
  wire busy_d;
  wire ack_d;

  // A new job starts only on a fresh request, never while an old one still holds ack.
  assign launch_out = req_in & ~req_q & ~ack_q & ~busy_q;
  assign finish_out = (IMMEDIATE != 0) ? launch_out : (busy_q & done_in);
  assign busy_d = (IMMEDIATE != 0) ? 1'b0 : ((busy_q | launch_out) & ~finish_out);
  // Ack is only raised if the request is still there; it falls when the request falls.
  assign ack_d = req_in & (ack_q | finish_out);
  assign busy_out = busy_q;
  assign ack_out = ack_q;

  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      ack_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      ack_q <= ack_d;
      req_q <= req_in;
    end
  end
endmodule // rmch_hs

/* testbench/rmch_hs_asserts.sv */
// Port assertions for the remote monitor and instruction handshake.
`timescale 1ns/1ns
module rmch_hs_asserts (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [4:0] bus_addr_in,
  input wire [15:0] bus_wdata_in,
  input wire bus_wr_in,
  input wire [15:0] instr_code_out,
  input wire instr_start_out,
  input wire instr_done_in,
  input wire monitor_ack_bit_out,
  input wire instruction_ack_bit_out
);
  // Request bits and code word are rebuilt from bus writes, since they are not ports.
  reg [1:0] req_q;
  reg [15:0] code_q;
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      req_q <= 2'h0;
      code_q <= 16'h0000;
    end else if (bus_wr_in) begin
      if (bus_addr_in == 5'h10) req_q <= bus_wdata_in[1:0];
      if (bus_addr_in == 5'h02) code_q <= bus_wdata_in;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_mon_ack_rise: assert property ($rose(req_q[0]) && !monitor_ack_bit_out
    |-> ##[1:3] monitor_ack_bit_out) else $error("monitor ack missing");
  a_mon_ack_hold: assert property (monitor_ack_bit_out && req_q[0]
    |=> monitor_ack_bit_out) else $error("monitor ack dropped early");
  a_mon_ack_drop: assert property ($fell(req_q[0])
    |-> ##[1:3] !monitor_ack_bit_out) else $error("monitor ack stuck");
  a_instr_launch: assert property ($rose(req_q[1]) && !instruction_ack_bit_out
    |-> ##[1:3] instr_start_out) else $error("instruction not started");
  a_instr_code: assert property (instr_start_out
    |-> instr_code_out == code_q) else $error("wrong instruction code");
  a_instr_ack_cause: assert property ($rose(instruction_ack_bit_out)
    |-> $past(instr_done_in)) else $error("instruction ack without done");
  a_instr_ack_hold: assert property (instruction_ack_bit_out && req_q[1]
    |=> instruction_ack_bit_out) else $error("instruction ack dropped early");
  a_instr_ack_drop: assert property ($fell(req_q[1])
    |-> ##[1:3] !instruction_ack_bit_out) else $error("instruction ack stuck");
endmodule // rmch_hs_asserts
bind rmch_top rmch_hs_asserts u_chk (.*);

/* testbench/rmch_far.sv */
// Servo side model: monitor sources and instruction executor.
`timescale 1ns/1ns
module rmch_far (
  input wire sys_clk_in,
  input wire sys_rst_in,
  input wire [15:0] mon1_sel_out,
  input wire [15:0] mon2_sel_out,
  input wire instr_start_out,
  input wire [15:0] instr_code_out,
  output wire [31:0] mon1_data_in,
  output wire mon1_err_in,
  output wire [31:0] mon2_data_in,
  output wire mon2_err_in,
  output reg instr_done_in,
  output reg instr_err_in
);
  reg [3:0] cnt_q;
  assign mon1_data_in = {~mon1_sel_out, mon1_sel_out};
  assign mon1_err_in = |mon1_sel_out[15:8];
  assign mon2_data_in = {mon2_sel_out, mon2_sel_out ^ 16'h5A5A};
  assign mon2_err_in = |mon2_sel_out[15:8];
  // Low code bits set the run time, so prompt and slow answers both occur.
  // The error line toggles away from done, as it carries no meaning there.
  always @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_q <= 4'h0;
      instr_done_in <= 1'b0;
      instr_err_in <= 1'b0;
    end else begin
      if (instr_start_out) cnt_q <= {1'b0, instr_code_out[2:0]} + 4'h1;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      instr_done_in <= cnt_q == 4'h1;
      instr_err_in <= cnt_q == 4'h1 ? &instr_code_out[15:12] : ~instr_err_in;
    end
  end
endmodule // rmch_far

/* testbench/tb_remote_monitor_command_handshake.sv */
// Self-checking bench of the remote monitor and instruction handshake.
`timescale 1ns/1ns
`include "rmch_regs.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_remote_monitor_command_handshake;
  reg sys_clk_in = 1'b0;
  reg sys_rst_in = 1'b1;
  reg [4:0] bus_addr_in = 5'h00;
  reg [15:0] bus_wdata_in = 16'h0000;
  reg bus_wr_in = 1'b0;
  reg bus_rd_in = 1'b0;
  wire [15:0] bus_rdata_out, mon1_sel_out, mon2_sel_out, instr_code_out;
  wire [31:0] mon1_data_in, mon2_data_in;
  wire mon1_err_in, mon2_err_in, instr_start_out, instr_done_in, instr_err_in;
  wire monitor_ack_bit_out, instruction_ack_bit_out;
  wire [1:0] acks = {instruction_ack_bit_out, monitor_ack_bit_out};
  int mismatches = 0, num_checks = 0, cyc = 0;
  reg [15:0] s1, s2, c;
  reg [31:0] d1, d2;
  rmch_top dut (.*);
  rmch_far u_far (.*);
  initial forever #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic wr(input [4:0] a, input [15:0] d);
    @(posedge sys_clk_in);
    bus_wr_in <= 1'b1;
    bus_addr_in <= a;
    bus_wdata_in <= d;
    @(posedge sys_clk_in);
    bus_wr_in <= 1'b0;
  endtask
  task automatic rd(input [4:0] a, input [15:0] e);
    @(posedge sys_clk_in);
    bus_rd_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge sys_clk_in);
    bus_rd_in <= 1'b0;
    #1 `CHK("read data", e, bus_rdata_out)
  endtask
  task automatic wack(input int w, input logic v);
    for (int i = 0; i < 20 && acks[w] !== v; i++) @(posedge sys_clk_in);
    #1 `CHK("ack", v, acks[w])
  endtask
  // Selections with a nonzero high byte are invalid and must give the error code.
  function automatic [15:0] rsel();
    rsel = $urandom_range(0, 3) ? ($urandom & 16'h00FF) : 16'($urandom);
  endfunction
  function automatic [15:0] rsp(input [15:0] a, input [15:0] b);
    rsp = |{a[15:8], b[15:8]} ? `RMCH_RESP_ERR : `RMCH_RESP_OK;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hB3B06004));
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    rd(5'h11, 16'h0000);
    rd(5'h1F, 16'h0000);
    wr(5'h08, 16'hFFFF);
    rd(5'h08, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      wr(5'h12, {15'h0000, m[0]});
      // Later rounds change selections under a standing request to prove refresh.
      for (int k = 0; k < 4; k++) begin
        s1 = rsel();
        s2 = rsel();
        d1 = {~s1, s1};
        d2 = {s2, s2 ^ 16'h5A5A};
        wr(5'h00, s1);
        wr(m ? 5'h02 : 5'h01, s2);
        if (k == 0) wr(5'h10, 16'h0001);
        wack(0, 1'b1);
        repeat (3) @(posedge sys_clk_in);
        rd(5'h08, d1[15:0]);
        rd(5'h09, m ? d1[31:16] : d2[15:0]);
        rd(5'h0A, rsp(s1, s2));
        if (m) rd(5'h0D, d2[15:0]);
        if (m) rd(5'h0E, d2[31:16]);
      end
      wr(5'h10, 16'h0000);
      wack(0, 1'b0);
    end
    wr(5'h12, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      c = {k[0] ? 4'hF : 4'h3, 12'($urandom)};
      wr(5'h02, c);
      wr(5'h10, 16'h0002);
      wack(1, 1'b1);
      rd(5'h11, 16'h0002);
      rd(5'h0A, k[0] ? `RMCH_RESP_ERR : `RMCH_RESP_OK);
      wr(5'h10, 16'h0000);
      wack(1, 1'b0);
    end
    report_and_stop();
  end
endmodule // tb_remote_monitor_command_handshake
